// file: common/pmbp_defines.svh
/*
 Timing counts, field positions and reset values for the parallel master bus port.
 Assumes inclusion by bare name from design files; definitions only.
*/
`ifndef PMBP_DEFINES_SVH
`define PMBP_DEFINES_SVH
`define PMBP_CLK_PERIOD_NS 10
`define PMBP_READ_CYCLES 2
`define PMBP_WRITE_CYCLES 3
`define PMBP_MUX_EXTRA_CYCLES 6
`define PMBP_MODE_BUSY_BIT 15
`define PMBP_MODE_EVENT_REQUEST_MODE_HI 14
`define PMBP_MODE_EVENT_REQUEST_MODE_LO 13
`define PMBP_MODE_WIDE_BIT 10
`define PMBP_MODE_STROBE_HI 9
`define PMBP_MODE_STROBE_LO 8
`define PMBP_EVENT_REQUEST_MODE_EVERY_STROBE 2'h1
`define PMBP_STROBE_MODE_TWO 2'h2
`define PMBP_STROBE_MODE_ONE 2'h3
`define PMBP_CSF_NONE 2'h0
`define PMBP_CSF_HIGH_ONLY 2'h2
`define PMBP_CSF_BOTH 2'h3
`define PMBP_DATA_RESET 16'h0000
`define PMBP_FIFO_DEPTH 16
`endif

// file: common/pmbp_pkg.sv
/*
 Types shared by the parallel master bus port design files.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package pmbp_pkg;
	typedef enum logic [1:0] {
		PMBP_IDLE = 2'b00,
		PMBP_RUN = 2'b01
	} pmbp_state_type;
	typedef enum logic [1:0] {
		PMBP_XFER_READ = 2'b00,
		PMBP_XFER_WRITE = 2'b01
	} pmbp_xfer_type;
endpackage

// file: verilog/pmbp_fifo.sv
/*
 Synchronous FIFO with valid/ready on both sides, storage in flip-flops.
 Assumes a single clock and a synchronous active-high reset.
*/
`timescale 1ns/1ns
module pmbp_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 16
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr;
	logic [AW-1:0] rd_ptr;
	logic [AW:0] count;
	wire push = in_valid && in_ready;
	wire pop = out_valid && out_ready;

	// full and empty straight from the occupancy count
	assign in_ready = (count != (AW+1)'(DEPTH));
	assign out_valid = (count != '0);
	assign out_data = mem[rd_ptr];

	// pointers wrap naturally because depth is a power of two
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end else begin
			if (push) begin
				mem[wr_ptr] <= in_data;
				wr_ptr <= wr_ptr + 1'b1;
			end
			if (pop)
				rd_ptr <= rd_ptr + 1'b1;
			count <= count + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule

// file: verilog/pmbp_master.sv
/*
 Master-mode transaction engine of the parallel master bus port: software
 reads/writes of the bus data register launch external cycles; read data is
 buffered through a 16-word FIFO before landing in the data register.
 Assumes the software access strobes are single-cycle pulses on ref_clk and
 that the data pin inputs come from outside, so they are synchronised here.
*/
// Operation
// - data read returns latch, launches read cycle
// - read pulses read strobe or rw+enable
// - captured data returned by next read
// - wide mode captures sixteen pins, else eight
// - write asserts selects, then drives data, strobes
// - write drives sixteen or low eight bits
// - event flag set on every strobe
// - interrupt only when request mode 01, enabled
// - busy readable at mode bit fifteen
// - busy high except the final cycle
// - access ignored as trigger while busy
// - selects: both, high only, never low only
// - select asserts only when address bit set
// - both selects may assert together
// - auto-increment leaves select bits alone
// - fully multiplexed bus zeroes only the enabled select bits
// - mode 10 strobe two, 11 strobe one
// - demux read two cycles, write three
`timescale 1ns/1ns
`include "pmbp_defines.svh"
module pmbp_master (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic data_read_pulse,
	input wire logic data_write_pulse,
	input wire logic [15:0] data_write_value,
	output logic [15:0] bus_data_register,
	input wire logic [15:0] bus_address_register,
	input wire logic [1:0] strobe_mode,
	input wire logic wide_data_select,
	input wire logic [1:0] event_request_mode,
	input wire logic port_event_enable,
	input wire logic [1:0] chip_select_enable,
	input wire logic [1:0] address_mux_select,
	input wire logic auto_increment,
	input wire logic event_flag_clear,
	output logic [15:0] port_mode_register,
	output logic busy,
	output logic port_event_flag,
	output logic event_request,
	output logic [15:0] next_address,
	output logic address_update,
	output logic chip_select_high,
	output logic chip_select_low,
	output logic [13:0] parallel_address_pins,
	output logic [15:0] parallel_data_out,
	output logic [15:0] parallel_data_oe,
	input wire logic [15:0] parallel_data_in,
	output logic read_strobe,
	output logic write_strobe_line,
	output logic read_write_line,
	output logic enable_strobe,
	output logic fifo_in_ready
);
	import pmbp_pkg::*;

	pmbp_state_type state;
	pmbp_xfer_type xfer;
	logic [3:0] cycle;
	logic [3:0] last_cycle;
	logic [15:0] addr_hold;
	logic [15:0] wdata_hold;
	logic [15:0] din_meta;
	logic [15:0] din_sync;
	logic strobe_now;
	logic fifo_out_valid;
	logic [15:0] fifo_out_data;
	logic rd_done_d1;
	logic rd_done_d2;

	// cycle count of a transaction for given mux setting
	function automatic logic [3:0] xfer_len(input logic is_write, input logic [1:0] mux);
		logic [3:0] base;
		base = is_write ? 4'(`PMBP_WRITE_CYCLES) : 4'(`PMBP_READ_CYCLES);
		case (mux)
			2'h0: xfer_len = base;
			2'h2: xfer_len = base + 4'(`PMBP_MUX_EXTRA_CYCLES);
			default: xfer_len = base + 4'h3;
		endcase
	endfunction

	// master modes only; low-only select config collapses to none
	wire master_mode = (strobe_mode == `PMBP_STROBE_MODE_TWO) ||
		(strobe_mode == `PMBP_STROBE_MODE_ONE);
	wire cs_high_en = chip_select_enable[1];
	wire cs_low_en = (chip_select_enable == `PMBP_CSF_BOTH);
	wire fully_mux = address_mux_select[1];
	wire start_ok = master_mode && (state == PMBP_IDLE) && !busy;
	wire start_read = start_ok && data_read_pulse;
	wire start_write = start_ok && data_write_pulse && !data_read_pulse;
	wire final_cycle = (state == PMBP_RUN) && (cycle == last_cycle);
	wire [15:0] mux_addr = {addr_hold[15] & ~cs_high_en, addr_hold[14] & ~cs_low_en,
		addr_hold[13:0]};
	wire [15:0] captured = wide_data_select ? din_sync : {8'h00, din_sync[7:0]};

	// busy readable together with the mode fields
	assign port_mode_register = {busy, event_request_mode, 2'h0, wide_data_select,
		strobe_mode, 8'h00};
	assign event_request = port_event_flag && port_event_enable &&
		(event_request_mode == `PMBP_EVENT_REQUEST_MODE_EVERY_STROBE);

	// sequencer: idle, then a run of last_cycle+1 clocks
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			state <= PMBP_IDLE;
			xfer <= PMBP_XFER_READ;
			cycle <= 4'h0;
			last_cycle <= 4'h0;
			addr_hold <= 16'h0000;
			wdata_hold <= 16'h0000;
		end else if (start_read || start_write) begin
			state <= PMBP_RUN;
			xfer <= start_write ? PMBP_XFER_WRITE : PMBP_XFER_READ;
			cycle <= 4'h0;
			last_cycle <= xfer_len(start_write, address_mux_select) - 4'h1;
			addr_hold <= bus_address_register;
			wdata_hold <= data_write_value;
		end else if (final_cycle) begin
			state <= PMBP_IDLE;
		end else if (state == PMBP_RUN) begin
			cycle <= cycle + 4'h1;
		end
	end

	// busy high for every cycle but the last
	assign busy = (state == PMBP_RUN) && !final_cycle;

	// strobe sits in the last cycle; write drives data from cycle 1 on, at least one cycle before it
	assign strobe_now = (state == PMBP_RUN) && (cycle == last_cycle);

	// pin outputs registered so they stay glitch free
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			chip_select_high <= 1'b0;
			chip_select_low <= 1'b0;
			parallel_address_pins <= 14'h0000;
			parallel_data_out <= 16'h0000;
			parallel_data_oe <= 16'h0000;
			read_strobe <= 1'b0;
			write_strobe_line <= 1'b0;
			read_write_line <= 1'b0;
			enable_strobe <= 1'b0;
		end else begin
			chip_select_high <= (state == PMBP_RUN) && cs_high_en && addr_hold[15];
			chip_select_low <= (state == PMBP_RUN) && cs_low_en && addr_hold[14];
			parallel_address_pins <= addr_hold[13:0];
			if (state == PMBP_RUN && xfer == PMBP_XFER_WRITE && cycle != 4'h0) begin
				parallel_data_out <= wide_data_select ? wdata_hold
					: {8'h00, wdata_hold[7:0]};
				parallel_data_oe <= wide_data_select ? 16'hFFFF : 16'h00FF;
			end else if (state == PMBP_RUN && fully_mux && cycle == 4'h0) begin
				parallel_data_out <= mux_addr;
				parallel_data_oe <= 16'hFFFF;
			end else begin
				parallel_data_out <= 16'h0000;
				parallel_data_oe <= 16'h0000;
			end
			read_strobe <= strobe_now && xfer == PMBP_XFER_READ &&
				strobe_mode == `PMBP_STROBE_MODE_TWO;
			write_strobe_line <= strobe_now && xfer == PMBP_XFER_WRITE &&
				strobe_mode == `PMBP_STROBE_MODE_TWO;
			read_write_line <= (state == PMBP_RUN) && xfer == PMBP_XFER_WRITE &&
				strobe_mode == `PMBP_STROBE_MODE_ONE;
			enable_strobe <= strobe_now && strobe_mode == `PMBP_STROBE_MODE_ONE;
		end
	end

	// data pins come from outside: two flops before use
	always_ff @(posedge ref_clk) begin
		din_meta <= parallel_data_in;
		din_sync <= din_meta;
	end

	// push trails the final cycle by two, so din_sync holds what stood in that cycle
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			rd_done_d1 <= 1'b0;
			rd_done_d2 <= 1'b0;
		end else begin
			rd_done_d1 <= final_cycle && xfer == PMBP_XFER_READ;
			rd_done_d2 <= rd_done_d1;
		end
	end

	// captured words queue here; data register drains one per cycle without a read pulse
	pmbp_fifo #(
		.WIDTH(16),
		.DEPTH(`PMBP_FIFO_DEPTH)
	) u_fifo (
		.ref_clk(ref_clk),
		.rst(rst),
		.in_valid(rd_done_d2),
		.in_ready(fifo_in_ready),
		.in_data(captured),
		.out_valid(fifo_out_valid),
		.out_ready(!data_read_pulse),
		.out_data(fifo_out_data)
	);

	// a write launch loads the latch; read data lands only after the read that launched it returned old data
	always_ff @(posedge ref_clk) begin
		if (rst)
			bus_data_register <= `PMBP_DATA_RESET;
		else if (start_write)
			bus_data_register <= data_write_value;
		else if (fifo_out_valid && !data_read_pulse)
			bus_data_register <= fifo_out_data;
	end

	// event flag: set wins over clear
	always_ff @(posedge ref_clk) begin
		if (rst)
			port_event_flag <= 1'b0;
		else if (strobe_now)
			port_event_flag <= 1'b1;
		else if (event_flag_clear)
			port_event_flag <= 1'b0;
	end

	// increment proposal keeps select bits untouched
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			next_address <= 16'h0000;
			address_update <= 1'b0;
		end else begin
			address_update <= final_cycle && auto_increment;
			next_address <= {addr_hold[15:14], 14'(addr_hold[13:0] + 14'h1)};
		end
	end
endmodule

// file: bench/pmbp_monitor.sv
/* checker for the bus port master engine.
 assumes binding onto pmbp_master; one clock */
`timescale 1ns/1ns
module pmbp_monitor (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic data_read_pulse,
	input wire logic data_write_pulse,
	input wire logic [1:0] strobe_mode,
	input wire logic [1:0] address_mux_select,
	input wire logic [1:0] chip_select_enable,
	input wire logic [15:0] bus_address_register,
	input wire logic [1:0] event_request_mode,
	input wire logic port_event_enable,
	input wire logic [15:0] port_mode_register,
	input wire logic busy,
	input wire logic port_event_flag,
	input wire logic event_request,
	input wire logic chip_select_high,
	input wire logic chip_select_low,
	input wire logic read_strobe,
	input wire logic write_strobe_line,
	input wire logic enable_strobe
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	// a launch needs idle two cycles running, so a final cycle is not mistaken for idle
	sequence go_rd;
		data_read_pulse && !busy && !$past(busy) && strobe_mode[1] && address_mux_select == 2'h0;
	endsequence
	sequence go_wr;
		data_write_pulse && !data_read_pulse && !busy && !$past(busy) && strobe_mode[1]
			&& address_mux_select == 2'h0;
	endsequence
	sequence rd_run;
		##1 busy ##1 !busy ##1 (read_strobe || enable_strobe);
	endsequence
	sequence wr_run;
		##1 busy [*2] ##1 !busy ##1 (write_strobe_line || enable_strobe);
	endsequence
	a_read_timing: assert property (go_rd |-> rd_run)
		else $error("read cycle timing wrong");
	a_write_timing: assert property (go_wr |-> wr_run)
		else $error("write cycle timing wrong");
	a_strobe_flag: assert property ((read_strobe || write_strobe_line || enable_strobe)
		|-> ##[0:1] port_event_flag) else $error("strobe left flag clear");
	a_busy_bit: assert property (port_mode_register[15] == busy)
		else $error("busy bit differs");
	a_mode_field: assert property (port_mode_register[9:8] == strobe_mode)
		else $error("mode field differs");
	a_irq_gate: assert property (event_request |-> port_event_flag && port_event_enable
		&& event_request_mode == 2'h1) else $error("request without cause");
	a_cs_low: assert property (chip_select_low |-> chip_select_enable == 2'h3
		&& bus_address_register[14]) else $error("low select wrong");
	a_cs_high: assert property (chip_select_high |-> chip_select_enable[1]
		&& bus_address_register[15]) else $error("high select wrong");
	a_read_mode: assert property (read_strobe |-> strobe_mode == 2'h2)
		else $error("read strobe in wrong mode");
endmodule
bind pmbp_master pmbp_monitor u_mon (.ref_clk, .rst, .data_read_pulse, .data_write_pulse,
	.strobe_mode, .address_mux_select, .chip_select_enable, .bus_address_register,
	.event_request_mode, .port_event_enable, .port_mode_register, .busy, .port_event_flag,
	.event_request, .chip_select_high, .chip_select_low, .read_strobe, .write_strobe_line,
	.enable_strobe);

// file: bench/pmbp_periph.sv
/* far-side peripheral: sixteen words of memory.
 assumes active-high selects and strobes */
`timescale 1ns/1ns
module pmbp_periph (
	input wire logic ref_clk,
	input wire logic chip_select_high,
	input wire logic chip_select_low,
	input wire logic ext_sel,
	input wire logic [13:0] parallel_address_pins,
	input wire logic [15:0] parallel_data_out,
	input wire logic write_strobe_line,
	input wire logic read_write_line,
	input wire logic enable_strobe,
	output logic [15:0] parallel_data_in
);
	logic [15:0] mem [16];
	logic [15:0] last = 16'h0000;
	// ext_sel is a software select pin, held by the bench for the whole op
	wire sel = chip_select_high | chip_select_low | ext_sel;
	// mode one writes on the enable strobe while the read/write line is high
	wire wr_now = write_strobe_line | (enable_strobe & read_write_line);
	wire [3:0] a = parallel_address_pins[3:0];
	initial for (int i = 0; i < 16; i++) mem[i] = 16'h5A00 | 16'(i);
	// unselected bus shows the inverse, never a stale copy
	assign parallel_data_in = sel ? mem[a] : ~last;
	always @(posedge ref_clk) begin
		if (wr_now) mem[a] <= parallel_data_out;
		if (sel) last <= mem[a];
	end
endmodule

// file: bench/test_parallel_master_bus_port.sv
/* self-checking bench for pmbp_master.
 assumes 100 MHz clock, sync active-high reset */
`timescale 1ns/1ns
module test_parallel_master_bus_port;
	import pmbp_pkg::*;
	typedef struct {logic [1:0] md; logic wd; logic [1:0] ce, mx;
		logic [15:0] ad, wv, rb; logic [1:0] cs;} pmbp_row_type;
	logic ref_clk = 0, rst = 1, data_read_pulse = 0, data_write_pulse = 0, ext_sel = 0;
	logic wide_data_select = 0, port_event_enable = 0, auto_increment = 0;
	logic event_flag_clear = 0;
	logic [15:0] data_write_value = 16'h0000, bus_address_register = 16'h0000;
	logic [1:0] strobe_mode = 2'h0, event_request_mode = 2'h0;
	logic [1:0] chip_select_enable = 2'h0, address_mux_select = 2'h0;
	logic [15:0] bus_data_register, port_mode_register, next_address, parallel_data_out;
	logic [15:0] parallel_data_oe, parallel_data_in, sd, so, na;
	logic [13:0] parallel_address_pins;
	logic busy, port_event_flag, event_request, address_update, chip_select_high;
	logic chip_select_low, read_strobe, write_strobe_line, read_write_line;
	logic enable_strobe, fifo_in_ready;
	logic [4:0] nb, ns;
	logic [1:0] sc;
	int n_fail = 0, n_checks = 0, cyc = 0;
	int bw [4] = '{1, 4, 7, 4};
	// mode, wide, select enable, mux, address, written, read back, selects seen
	pmbp_row_type rows [7] = '{
		'{2'h2, 1, 2'h3, 2'h0, 16'hC005, 16'h1234, 16'h1234, 2'h3},
		'{2'h2, 0, 2'h2, 2'h0, 16'h4006, 16'hABCD, 16'h00CD, 2'h0},
		'{2'h3, 1, 2'h2, 2'h0, 16'h8007, 16'h0F0F, 16'h0F0F, 2'h2},
		'{2'h2, 1, 2'h1, 2'h1, 16'h8003, 16'h7777, 16'h7777, 2'h0},
		'{2'h2, 0, 2'h3, 2'h2, 16'h4004, 16'h3C5A, 16'h005A, 2'h1},
		'{2'h3, 1, 2'h0, 2'h3, 16'hC001, 16'h1111, 16'h1111, 2'h0},
		'{2'h3, 0, 2'h2, 2'h0, 16'h8008, 16'h2222, 16'h0022, 2'h2}};
	pmbp_master DUT (.ref_clk, .rst, .data_read_pulse, .data_write_pulse, .data_write_value,
		.bus_data_register, .bus_address_register, .strobe_mode, .wide_data_select,
		.event_request_mode, .port_event_enable, .chip_select_enable, .address_mux_select,
		.auto_increment, .event_flag_clear, .port_mode_register, .busy, .port_event_flag,
		.event_request, .next_address, .address_update, .chip_select_high, .chip_select_low,
		.parallel_address_pins, .parallel_data_out, .parallel_data_oe, .parallel_data_in,
		.read_strobe, .write_strobe_line, .read_write_line, .enable_strobe, .fifo_in_ready);
	pmbp_periph u_far (.ref_clk, .chip_select_high, .chip_select_low, .ext_sel,
		.parallel_address_pins, .parallel_data_out, .write_strobe_line, .read_write_line,
		.enable_strobe, .parallel_data_in);
	initial forever #5 ref_clk = ~ref_clk;
	// hang guard: a few hundred cycles are needed, far fewer than this
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 3000) begin
			n_fail++;
			print_verdict();
		end
	end
	task chk(input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("Error %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task print_verdict();
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	// one access; dbl holds the pulse into the busy cycle, which must be ignored
	task op(input logic rd, input logic dbl);
		nb = 0;
		ns = 0;
		na = 16'h0000;
		while (busy) @(negedge ref_clk);
		@(posedge ref_clk);
		if (rd) data_read_pulse <= 1'b1;
		else data_write_pulse <= 1'b1;
		@(posedge ref_clk);
		if (dbl) @(posedge ref_clk);
		data_read_pulse <= 1'b0;
		data_write_pulse <= 1'b0;
		repeat (16) begin
			@(negedge ref_clk);
			nb = nb + 5'(busy);
			if (address_update) na = next_address;
			if (read_strobe | write_strobe_line | enable_strobe) begin
				ns++;
				sd = parallel_data_out;
				so = parallel_data_oe;
				sc = {chip_select_high, chip_select_low};
			end
		end
	endtask
	initial begin
		repeat (10) @(posedge ref_clk);
		rst <= 1'b0;
		@(negedge ref_clk);
		chk(16'(busy), 16'h0000);
		chk(16'(port_event_flag), 16'h0000);
		chk(16'(fifo_in_ready), 16'h0001);
		foreach (rows[i]) begin
			@(posedge ref_clk);
			strobe_mode <= rows[i].md;
			wide_data_select <= rows[i].wd;
			chip_select_enable <= rows[i].ce;
			address_mux_select <= rows[i].mx;
			bus_address_register <= rows[i].ad;
			data_write_value <= rows[i].wv;
			ext_sel <= (rows[i].cs == 2'h0);
			op(0, 0);
			chk(16'(nb), 16'(bw[rows[i].mx] + 1));
			chk(16'(ns), 16'h0001);
			chk(sd, rows[i].wd ? rows[i].wv : {8'h00, rows[i].wv[7:0]});
			chk(so, rows[i].wd ? 16'hFFFF : 16'h00FF);
			chk(16'(sc), 16'(rows[i].cs));
			op(1, 0);
			chk(16'(nb), 16'(bw[rows[i].mx]));
			chk(bus_data_register, rows[i].rb);
		end
		// low field wraps to zero while the select bits stay put
		@(posedge ref_clk);
		auto_increment <= 1'b1;
		bus_address_register <= 16'hBFFF;
		op(1, 1);
		chk(16'(ns), 16'h0001);
		chk(na, 16'h8000);
		@(posedge ref_clk);
		strobe_mode <= 2'h0;
		op(0, 0);
		chk(16'(ns), 16'h0000);
		chk(16'(port_event_flag), 16'h0001);
		// every request mode with the enable set, then mode 00 with it clear
		for (int m = 0; m < 5; m++) begin
			@(posedge ref_clk);
			event_request_mode <= 2'(m);
			port_event_enable <= (m < 4);
			@(negedge ref_clk);
			chk(16'(event_request), 16'(m == 1));
			chk(16'(port_mode_register[14:13]), 16'(m % 4));
		end
		@(posedge ref_clk);
		event_request_mode <= 2'h1;
		port_event_enable <= 1'b1;
		event_flag_clear <= 1'b1;
		@(posedge ref_clk);
		event_flag_clear <= 1'b0;
		@(negedge ref_clk);
		chk(16'(port_event_flag), 16'h0000);
		chk(16'(event_request), 16'h0000);
		print_verdict();
	end
endmodule
